// [rtl/cap_pkg.sv]
package cap_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 250_000_000;
  localparam int TICK_TIME_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_TIME_S;
  localparam int HOUR_TIME_S = 3600;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] LPSET_OFS = 8'h04;
  localparam logic [7:0] AFSET_OFS = 8'h08;
  localparam logic [7:0] LIMIT_OFS = 8'h0c;
  localparam logic [7:0] BYPASS_OFS = 8'h10;
  localparam logic [7:0] MANRST_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;
  localparam logic [7:0] LOADS_OFS = 8'h1c;
  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int CFG_P6_PRESSURE_BIT = 0;
  localparam int CFG_SEPARATE_BIT = 1;
  localparam int CFG_P5FN_LSB = 4;
  localparam logic [3:0] P5FN_ANTIFREEZE = 4'h1;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] LPSET_RST = 32'h0000_0000;
  localparam logic [31:0] AFSET_RST = 32'h0000_0000;
  localparam logic [31:0] LIMIT_RST = 32'h0303_0303;
  localparam logic [31:0] BYPASS_RST = 32'h0000_0000;
  localparam logic [7:0] NO_LIMIT = 8'hff;
  localparam logic [7:0] ALWAYS_MANUAL = 8'h00;
  // ****************************************
  // Alarm indices
  // ****************************************
  localparam int N_ALARM = 8;
  localparam int A_LP_ANALOG = 0;
  localparam int A_THERM_C2 = 1;
  localparam int A_HP_C2 = 2;
  localparam int A_HP_CIRC2 = 3;
  localparam int A_LP_INPUT = 4;
  localparam int A_THERM_C3 = 5;
  localparam int A_FAN_THERM2 = 6;
  localparam int A_ANTIFREEZE = 7;
  localparam int N_BYP = 4;
endpackage

// [rtl/cap_protection.sv]
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
// What this block does
// - Circuit 1 low pressure stops circuit 1 compressors.
// - Analogue low pressure needs pressure probe configured.
// - Trip below setpoint, release above setpoint minus hysteresis.
// - Analogue low pressure latches after hourly limit.
// - Analogue low pressure bypassed after start or reversal.
// - Compressor 2 thermal input stops compressor 2.
// - Compressor 2 thermal bypass and hourly auto reset.
// - Compressor 2 high pressure, always manual reset.
// - Circuit 2 high pressure stops circuit 2.
// - Circuit 2 low pressure stops compressors, and its fans when separate.
// - Circuit 2 low pressure latches after hourly limit.
// - Circuit 2 low pressure bypassed after start, reversal.
// - Compressor 3 thermal stops it, hourly auto reset.
// - Compressor 3 thermal bypassed after compressor start.
// - Circuit 2 fan thermal stops circuit 2 loads.
// - Fan thermal input, hourly auto reset limit.
// - Anti-freeze only when probe five function selected.
// - Anti-freeze trips below setpoint, clears above plus hysteresis.
// - Anti-freeze shuts down every fan and compressor.
module cap_protection #(
  parameter int TICK_LEN = cap_pkg::TICK_CYCLES,
  parameter int HOUR_LEN = cap_pkg::HOUR_TIME_S
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Plant switches, active high on alarm
  input wire logic hpComp2Sw,
  input wire logic thermComp2Sw,
  input wire logic thermComp3Sw,
  input wire logic hpCirc2Sw,
  input wire logic lpCirc2Sw,
  input wire logic fanTherm2Sw,
  // Probe readings and plant events
  input wire logic signed [15:0] probeFive,
  input wire logic signed [15:0] probeSix,
  input wire logic [3:0] compStartPulse,
  input wire logic valveReverse1Pulse,
  // Load shutdown
  output logic [3:0] compStop,
  output logic [1:0] fanStop,
  output logic [7:0] alarmActive
);
  import cap_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [5:0] swMeta_q;
  logic [5:0] swSync_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      swMeta_q <= 6'h00;
      swSync_q <= 6'h00;
    end else begin
      swMeta_q <= {fanTherm2Sw, thermComp3Sw, lpCirc2Sw, hpCirc2Sw, hpComp2Sw, thermComp2Sw};
      swSync_q <= swMeta_q;
    end
  end

  // ****************************************
  // Seconds tick and hour window
  // ****************************************
  logic [27:0] tickCnt_q;
  logic secTick_q;
  logic [11:0] hourCnt_q;
  logic hourTick_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tickCnt_q <= 28'h0000000;
      secTick_q <= 1'b0;
    end else if (tickCnt_q == 28'(TICK_LEN - 1)) begin
      tickCnt_q <= 28'h0000000;
      secTick_q <= 1'b1;
    end else begin
      tickCnt_q <= tickCnt_q + 28'h0000001;
      secTick_q <= 1'b0;
    end
  end
  // The window restarts every hour rather than sliding; cheaper, slightly lenient.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hourCnt_q <= 12'h000;
      hourTick_q <= 1'b0;
    end else begin
      hourTick_q <= 1'b0;
      if (secTick_q) begin
        if (hourCnt_q == 12'(HOUR_LEN - 1)) begin
          hourCnt_q <= 12'h000;
          hourTick_q <= 1'b1;
        end else begin
          hourCnt_q <= hourCnt_q + 12'h001;
        end
      end
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  logic [31:0] cfg_q;
  logic [31:0] lpSet_q;
  logic [31:0] afSet_q;
  logic [31:0] limit_q;
  logic [31:0] bypass_q;
  logic [7:0] manRst_q;
  logic [7:0] latch_q;
  logic apbWrite;
  logic mapped;
  assign apbWrite = psel && penable && pwrite;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= LOADS_OFS);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= CFG_RST;
      lpSet_q <= LPSET_RST;
      afSet_q <= AFSET_RST;
      limit_q <= LIMIT_RST;
      bypass_q <= BYPASS_RST;
      manRst_q <= 8'h00;
    end else begin
      manRst_q <= 8'h00;
      if (apbWrite) begin
        case (paddr)
          CFG_OFS: cfg_q <= pwdata;
          LPSET_OFS: lpSet_q <= pwdata;
          AFSET_OFS: afSet_q <= pwdata;
          LIMIT_OFS: limit_q <= pwdata;
          BYPASS_OFS: bypass_q <= pwdata;
          MANRST_OFS: manRst_q <= pwdata[7:0];
          default: manRst_q <= 8'h00;
        endcase
      end
    end
  end
  // Read data is prepared in the setup cycle, so every access has no wait state.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b1;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        pslverr <= !mapped;
        case (paddr)
          CFG_OFS: prdata <= cfg_q;
          LPSET_OFS: prdata <= lpSet_q;
          AFSET_OFS: prdata <= afSet_q;
          LIMIT_OFS: prdata <= limit_q;
          BYPASS_OFS: prdata <= bypass_q;
          STATUS_OFS: prdata <= {16'h0000, latch_q, alarmActive};
          LOADS_OFS: prdata <= {26'h0000000, fanStop, compStop};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************
  // Analogue thresholds with hysteresis
  // ****************************************
  logic p6Pressure;
  logic separate;
  logic p5Antifreeze;
  logic signed [16:0] lpSp;
  logic signed [16:0] lpRel;
  logic signed [16:0] afSp;
  logic signed [16:0] afRel;
  logic lpLow_q;
  logic afLow_q;
  assign p6Pressure = cfg_q[CFG_P6_PRESSURE_BIT];
  assign separate = cfg_q[CFG_SEPARATE_BIT];
  assign p5Antifreeze = cfg_q[CFG_P5FN_LSB +: 4] == P5FN_ANTIFREEZE;
  assign lpSp = {lpSet_q[15], lpSet_q[15:0]};
  assign lpRel = lpSp - {lpSet_q[31], lpSet_q[31:16]};
  assign afSp = {afSet_q[15], afSet_q[15:0]};
  assign afRel = afSp + {afSet_q[31], afSet_q[31:16]};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lpLow_q <= 1'b0;
    end else if (!p6Pressure) begin
      lpLow_q <= 1'b0;
    end else if (17'(probeSix) < lpSp) begin
      lpLow_q <= 1'b1;
    end else if (17'(probeSix) > lpRel) begin
      lpLow_q <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      afLow_q <= 1'b0;
    end else if (!p5Antifreeze) begin
      afLow_q <= 1'b0;
    end else if (17'(probeFive) < afSp) begin
      afLow_q <= 1'b1;
    end else if (17'(probeFive) > afRel) begin
      afLow_q <= 1'b0;
    end
  end

  // ****************************************
  // Start-up bypass timers
  // ****************************************
  logic [N_BYP-1:0] bypTrig;
  logic [7:0] bypTime [N_BYP];
  logic [7:0] bypCnt_q [N_BYP];
  logic [N_BYP-1:0] bypOn;
  assign bypTrig[0] = |compStartPulse[1:0] || valveReverse1Pulse;
  assign bypTrig[1] = compStartPulse[1];
  assign bypTrig[2] = compStartPulse[2];
  // The valve named for the circuit 2 input is that of circuit 1, as printed.
  assign bypTrig[3] = |compStartPulse[3:2] || valveReverse1Pulse;
  assign bypTime[0] = bypass_q[7:0];
  assign bypTime[1] = bypass_q[15:8];
  assign bypTime[2] = bypass_q[15:8];
  assign bypTime[3] = bypass_q[23:16];
  for (genvar b = 0; b < N_BYP; b++) begin : gBypass
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        bypCnt_q[b] <= 8'h00;
      end else if (bypTrig[b]) begin
        bypCnt_q[b] <= bypTime[b];
      end else if (secTick_q && bypCnt_q[b] != 8'h00) begin
        bypCnt_q[b] <= bypCnt_q[b] - 8'h01;
      end
    end
    assign bypOn[b] = bypCnt_q[b] != 8'h00;
  end

  // ****************************************
  // Alarm cells with hourly auto reset
  // ****************************************
  logic [N_ALARM-1:0] raw;
  logic [N_ALARM-1:0] gated;
  logic [N_ALARM-1:0] prev_q;
  logic [7:0] limit [N_ALARM];
  logic [7:0] evCnt_q [N_ALARM];
  assign raw[A_LP_ANALOG] = lpLow_q;
  assign raw[A_THERM_C2] = swSync_q[0];
  assign raw[A_HP_C2] = swSync_q[1];
  assign raw[A_HP_CIRC2] = swSync_q[2];
  assign raw[A_LP_INPUT] = swSync_q[3];
  assign raw[A_THERM_C3] = swSync_q[4];
  assign raw[A_FAN_THERM2] = swSync_q[5];
  assign raw[A_ANTIFREEZE] = afLow_q;
  assign gated[A_LP_ANALOG] = raw[A_LP_ANALOG] && !bypOn[0];
  assign gated[A_THERM_C2] = raw[A_THERM_C2] && !bypOn[1];
  assign gated[A_HP_C2] = raw[A_HP_C2];
  assign gated[A_HP_CIRC2] = raw[A_HP_CIRC2];
  assign gated[A_LP_INPUT] = raw[A_LP_INPUT] && !bypOn[3];
  assign gated[A_THERM_C3] = raw[A_THERM_C3] && !bypOn[2];
  assign gated[A_FAN_THERM2] = raw[A_FAN_THERM2];
  assign gated[A_ANTIFREEZE] = raw[A_ANTIFREEZE];
  assign limit[A_LP_ANALOG] = limit_q[7:0];
  assign limit[A_THERM_C2] = limit_q[15:8];
  assign limit[A_HP_C2] = ALWAYS_MANUAL;
  assign limit[A_HP_CIRC2] = NO_LIMIT;
  assign limit[A_LP_INPUT] = limit_q[23:16];
  assign limit[A_THERM_C3] = limit_q[15:8];
  assign limit[A_FAN_THERM2] = limit_q[31:24];
  assign limit[A_ANTIFREEZE] = NO_LIMIT;
  for (genvar i = 0; i < N_ALARM; i++) begin : gAlarm
    logic event_d;
    logic [7:0] cnt_d;
    logic [7:0] newCnt;
    assign event_d = gated[i] && !prev_q[i];
    assign cnt_d = (evCnt_q[i] == 8'hff) ? evCnt_q[i] : evCnt_q[i] + 8'h01;
    // An event on the hour tick opens the new window, so it must not latch on the old count.
    assign newCnt = hourTick_q ? 8'h01 : cnt_d;
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        prev_q[i] <= 1'b0;
        evCnt_q[i] <= 8'h00;
      end else begin
        prev_q[i] <= gated[i];
        if (hourTick_q) begin
          evCnt_q[i] <= event_d ? 8'h01 : 8'h00;
        end else if (event_d) begin
          evCnt_q[i] <= cnt_d;
        end
      end
    end
    // A new event in the clearing cycle keeps the latch set.
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        latch_q[i] <= 1'b0;
      end else if (event_d && newCnt >= limit[i]) begin
        latch_q[i] <= 1'b1;
      end else if (manRst_q[i] && !gated[i]) begin
        latch_q[i] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Load shutdown
  // ****************************************
  logic [N_ALARM-1:0] act;
  assign act = gated | latch_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      compStop <= 4'h0;
      fanStop <= 2'h0;
      alarmActive <= 8'h00;
    end else begin
      alarmActive <= act;
      compStop[0] <= act[A_LP_ANALOG] || (act[A_FAN_THERM2] && !separate)
        || act[A_ANTIFREEZE];
      compStop[1] <= act[A_LP_ANALOG] || act[A_THERM_C2] || act[A_HP_C2]
        || (act[A_FAN_THERM2] && !separate) || act[A_ANTIFREEZE];
      compStop[2] <= act[A_HP_CIRC2] || act[A_LP_INPUT] || act[A_THERM_C3]
        || act[A_FAN_THERM2] || act[A_ANTIFREEZE];
      compStop[3] <= act[A_HP_CIRC2] || act[A_LP_INPUT] || act[A_FAN_THERM2]
        || act[A_ANTIFREEZE];
      fanStop[0] <= (act[A_LP_ANALOG] && separate) || act[A_ANTIFREEZE];
      fanStop[1] <= (act[A_LP_INPUT] && separate) || act[A_FAN_THERM2]
        || act[A_ANTIFREEZE];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_lp_stops_c1: assert property (act[A_LP_ANALOG] |=> compStop[0] && compStop[1])
    else $error("lp analog alarm did not stop circuit 1");
  a_lp_probe_off: assert property (!p6Pressure |=> !lpLow_q)
    else $error("lp analog alarm set without pressure probe");
  a_lp_trip: assert property (p6Pressure && 17'(probeSix) < lpSp |=> lpLow_q)
    else $error("lp analog alarm missed trip");
  a_lp_latch_cnt: assert property ($rose(latch_q[A_LP_ANALOG])
    |-> evCnt_q[A_LP_ANALOG] >= limit[A_LP_ANALOG])
    else $error("lp analog latched before limit");
  // A one-second bypass may end on the next tick, so only longer ones hold for two cycles.
  a_lp_bypass: assert property (bypTrig[0] && bypTime[0] > 8'h01
    |=> !gated[A_LP_ANALOG] [*2])
    else $error("lp analog alarm seen during bypass");
  a_therm2_stop: assert property (gated[A_THERM_C2] |=> compStop[1])
    else $error("comp 2 thermal did not stop comp 2");
  a_hp2_hold: assert property (latch_q[A_HP_C2] && !manRst_q[A_HP_C2]
    |=> latch_q[A_HP_C2])
    else $error("comp 2 high pressure released without reset");
  a_hp2_latch: assert property ($rose(gated[A_HP_C2]) |=> latch_q[A_HP_C2])
    else $error("comp 2 high pressure did not latch");
  a_circ2_hp: assert property (gated[A_HP_CIRC2] |=> compStop[2] && compStop[3])
    else $error("circuit 2 high pressure did not stop circuit 2");
  a_af_all: assert property (afLow_q |=> &compStop && &fanStop)
    else $error("anti-freeze did not stop all loads");
  a_lp_release: assert property (p6Pressure && 17'(probeSix) >= lpSp
    && 17'(probeSix) > lpRel |=> !lpLow_q)
    else $error("lp analog alarm missed release");
  a_lp2_stop: assert property (gated[A_LP_INPUT] |=> compStop[3:2] == 2'b11)
    else $error("circuit 2 low pressure did not stop circuit 2");
  a_lp2_fans: assert property (gated[A_LP_INPUT] && separate |=> fanStop[1])
    else $error("circuit 2 low pressure did not stop its fans");
  a_fan2_stop: assert property (gated[A_FAN_THERM2] && !separate
    |=> &compStop && fanStop[1])
    else $error("fan thermal did not stop both circuits");
  a_af_probe_off: assert property (!p5Antifreeze |=> !afLow_q)
    else $error("anti-freeze alarm set without probe function");
  c_lp_latch: cover property ($rose(latch_q[A_LP_ANALOG]));
  c_af_trip: cover property ($rose(afLow_q));
  c_manual_clear: cover property ($fell(latch_q[A_LP_INPUT]));
  c_bypass_run: cover property (bypOn[1] && raw[A_THERM_C2]);
endmodule

// [test/cap_plant.sv]
`timescale 1ns/100ps
// ****************************************
// Compressor relays and four-way valve
// ****************************************
module cap_plant (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Requests from the bench
  input wire logic [3:0] startReq,
  input wire logic valveReq,
  // Relay commands from the protection block
  input wire logic [3:0] compStop,
  // Events towards the protection block
  output logic [3:0] compStartPulse,
  output logic valveReverse1Pulse
);
  logic [3:0] compOn_q;
  // A held relay blocks a start, so no start event is seen for a stopped compressor.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      compOn_q <= 4'h0;
      compStartPulse <= 4'h0;
    end else begin
      compStartPulse <= startReq & ~compOn_q & ~compStop;
      compOn_q <= (compOn_q | startReq) & ~compStop;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      valveReverse1Pulse <= 1'b0;
    end else begin
      valveReverse1Pulse <= valveReq;
    end
  end
endmodule

// [test/cap_protection_tb_top.sv]
`timescale 1ns/100ps
module cap_protection_tb_top;
  import cap_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, valveReq, valvePulse;
  logic [7:0] paddr, alarmActive;
  logic [31:0] pwdata, prdata, seed;
  logic signed [15:0] probeFive, probeSix;
  logic [3:0] startPulse, startReq, compStop;
  logic [1:0] fanStop;
  logic [5:0] sw;
  logic [13:0] e;
  logic [13:0] outQ[$];
  logic [32:0] rdQ[$];
  int miscompares, checksDone, cyc;
  event lookEv;
  cap_protection #(.TICK_LEN(10), .HOUR_LEN(20)) cap_protection_i (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .thermComp2Sw(sw[0]), .hpComp2Sw(sw[1]), .hpCirc2Sw(sw[2]), .lpCirc2Sw(sw[3]),
    .thermComp3Sw(sw[4]), .fanTherm2Sw(sw[5]), .probeFive(probeFive), .probeSix(probeSix),
    .compStartPulse(startPulse), .valveReverse1Pulse(valvePulse),
    .compStop(compStop), .fanStop(fanStop), .alarmActive(alarmActive));
  cap_plant cap_plant_i (
    .clk(clk), .rstn(rstn), .startReq(startReq), .valveReq(valveReq), .compStop(compStop),
    .compStartPulse(startPulse), .valveReverse1Pulse(valvePulse));
  // ****************************************
  // Helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [13:0] sw_exp(input int i, input logic sep);
    case (i)
      0: return {8'h02, 4'b0010, 2'b00};
      1: return {8'h04, 4'b0010, 2'b00};
      2: return {8'h08, 4'b1100, 2'b00};
      3: return {8'h10, 4'b1100, sep, 1'b0};
      4: return {8'h20, 4'b0100, 2'b00};
      default: return {8'h40, sep ? 4'b1100 : 4'b1111, 2'b10};
    endcase
  endfunction
  // A probe value from 101 to 356, just above the low-pressure trip point and above the release point.
  function automatic logic signed [15:0] rnd6();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return 16'sd101 + $signed({8'h00, seed[7:0]});
  endfunction
  task cmp_out(input logic [13:0] x, input logic [13:0] g);
    checksDone++;
    if (g !== x) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task cmp_rd(input logic [32:0] x, input logic [32:0] g);
    checksDone++;
    if (g !== x) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task print_verdict();
    if (miscompares == 0 && checksDone > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task look(input logic [13:0] x);
    @(negedge clk);
    outQ.push_back(x);
    ->lookEv;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) rdQ.push_back(x);
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task pr(input logic signed [15:0] p6, input logic signed [15:0] p5, input logic [13:0] x);
    @(posedge clk);
    probeSix <= p6;
    probeFive <= p5;
    wt(5);
    look(x);
  endtask
  // ****************************************
  // Monitors and timeout
  // ****************************************
  always begin
    @(lookEv);
    cmp_out(outQ.pop_front(), {alarmActive, compStop, fanStop});
  end
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && rdQ.size() > 0) begin
      cmp_rd(rdQ.pop_front(), {pslverr, prdata});
    end
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, valveReq, startReq, sw} = '0;
    seed = 32'h64d9acde;
    probeSix = 16'sd500;
    probeFive = 16'sd500;
    wt(10);
    rstn <= 1'b1;
    apb(1'b0, CFG_OFS, 32'h0, {1'b0, CFG_RST});
    apb(1'b0, LIMIT_OFS, 32'h0, {1'b0, LIMIT_RST});
    apb(1'b0, 8'h20, 32'h0, {1'b1, 32'h0});
    for (int k = 0; k < 3; k++) begin
      wr(CFG_OFS, {30'h0, k != 0, 1'b0});
      wr(LIMIT_OFS, k == 2 ? 32'h0101_0101 : 32'hffff_ffff);
      for (int i = 0; i < 6; i++) begin
        e = sw_exp(i, k != 0);
        @(posedge clk) sw[i] <= 1'b1;
        wt(6);
        look(e);
        apb(1'b0, LOADS_OFS, 32'h0, {1'b0, 26'h0, e[1:0], e[5:2]});
        @(posedge clk) sw[i] <= 1'b0;
        wt(6);
        if (i == 1 || (k == 2 && i != 2)) begin
          look(e);
          apb(1'b0, STATUS_OFS, 32'h0, {17'h0, e[13:6], e[13:6]});
          wr(MANRST_OFS, {24'h0, e[13:6]});
          wt(3);
        end
        look(14'h0);
      end
    end
    wr(LIMIT_OFS, 32'hffff_ffff);
    wr(LPSET_OFS, 32'h000a_0064);
    wr(AFSET_OFS, 32'h0005_0032);
    wr(CFG_OFS, 32'h0000_0022);
    pr(16'sd50, 16'sd40, 14'h0);
    wr(CFG_OFS, 32'h0000_0023);
    pr(16'sd100, 16'sd40, 14'h0);
    pr(16'sd99, 16'sd40, {8'h01, 4'b0011, 2'b01});
    pr(rnd6(), 16'sd40, 14'h0);
    wr(CFG_OFS, 32'h0000_0011);
    pr(16'sd99, 16'sd500, {8'h01, 4'b0011, 2'b00});
    pr(rnd6(), 16'sd50, 14'h0);
    pr(rnd6(), 16'sd49, {8'h80, 4'hf, 2'h3});
    pr(rnd6(), 16'sd52, {8'h80, 4'hf, 2'h3});
    pr(rnd6(), 16'sd56, 14'h0);
    wr(LIMIT_OFS, 32'hffff_ff01);
    pr(16'sd99, 16'sd500, {8'h01, 4'b0011, 2'b00});
    pr(rnd6(), 16'sd500, {8'h01, 4'b0011, 2'b00});
    wr(MANRST_OFS, 32'h0000_0001);
    wt(3);
    look(14'h0);
    wr(LIMIT_OFS, 32'hffff_ffff);
    wr(BYPASS_OFS, 32'h0003_0303);
    wr(CFG_OFS, 32'h0000_0003);
    @(posedge clk) startReq <= 4'b0110;
    @(posedge clk) begin
      startReq <= 4'h0;
      sw <= 6'b011001;
    end
    wt(6);
    look(14'h0);
    wt(50);
    look({8'h32, 4'b1110, 2'b10});
    @(posedge clk) sw <= 6'h0;
    wt(6);
    look(14'h0);
    @(posedge clk) valveReq <= 1'b1;
    @(posedge clk) begin
      valveReq <= 1'b0;
      probeSix <= 16'sd99;
    end
    wt(6);
    look(14'h0);
    wt(50);
    look({8'h01, 4'b0011, 2'b01});
    pr(rnd6(), 16'sd500, 14'h0);
    print_verdict();
  end
endmodule
